// >>> core/fault_prot_pkg.sv
// Constants for the power switch protection and fault reporting logic.
// Assumes one 20 MHz clock and a synchronous active-high reset.
package fault_prot_pkg;
  localparam int CLK_HZ = 20_000_000;
  // Overcurrent detection delay window in ns
  localparam int DETECT_DELAY_NS = 150;
  localparam int DETECT_DELAY_CYC = (DETECT_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Short-circuit latch reset low time in ns
  localparam int SC_RESET_NS = 350_000;
  localparam int SC_RESET_CYC = (SC_RESET_NS / 1000) * (CLK_HZ / 1_000_000);
  // Falling-edge blank time in diode emulation, ns
  localparam int BLANK_NS = 200;
  localparam int BLANK_CYC = (BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Glitch filter length in cycles
  localparam int FILT_CYC = 3;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] DETECT_DELAY_C = CNT_W'(DETECT_DELAY_CYC);
  localparam logic [CNT_W-1:0] BLANK_C = CNT_W'(BLANK_CYC);
  localparam logic [CNT_W-1:0] FILT_C = CNT_W'(FILT_CYC);
  localparam int SC_RESET_DEFAULT = SC_RESET_CYC;

  typedef enum logic [1:0]
  {
    IDM_BLANK = 2'b01,
    IDM_MONITOR = 2'b10,
    IDM_ON = 2'b11
  } idm_state_type;
endpackage

// >>> core/sync_filter.sv
// Two-flop synchroniser followed by a stable-count glitch filter.
// Assumes the input is asynchronous to clk.
`timescale 1ns/10ps
module sync_filter
  import fault_prot_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Raw and filtered level
  input wire logic din,
  output logic dout
);
  logic s1_r;
  logic s2_r;
  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
    end
  end

  // Output follows only after a stable run
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cnt_r <= CNT_ZERO;
      dout <= 1'b0;
    end
    else if (s2_r == dout)
      cnt_r <= CNT_ZERO;
    else if (cnt_r + CNT_ONE >= FILT_C)
    begin
      cnt_r <= CNT_ZERO;
      dout <= s2_r;
    end
    else
      cnt_r <= cnt_r + CNT_ONE;
  end
endmodule // sync_filter

// >>> core/fault_protect.sv
// Protection and fault reporting of a power switch with gate driver.
// Assumes analog comparators drive the raw inputs asynchronously.
`timescale 1ns/10ps

// Contract
// RULE1: Overcurrent after delay: switch off, flag low; during diode emulation the switch follows the emulation state instead
// RULE2: Overcurrent clears on gate low, no latch
// RULE3: Delayed detect before short threshold: overcurrent
// RULE4: Short threshold first: short-circuit fault
// RULE5: Short-circuit turn-off uses slowed driver
// RULE6: Short-circuit latched until long gate low
// RULE7: Fault outputs push-pull, active low, high idle
// RULE8: Encoding normal 11, fault 01, oc 10, sc 00
// RULE9: Transistor overtemp enters diode emulation
// RULE10: Emulation: off first quadrant, on third
// RULE11: Driver overtemp shuts rails and transistor
// RULE12: No diode emulation during driver overtemp
// RULE13: Fault low during overtemp, auto release
// RULE14: Driver cools first: resume diode emulation
// RULE15: Undervoltage: transistor off, fault low
// RULE16: Rails enable on lockout release, off low
// RULE17: Fault low until series transistor on
// RULE18: Open slew-set pin holds fault low
// RULE19: Overcurrent pin grounded at power-up: fault only
// RULE20: Protection independent of fault pin use
// RULE21: Gate fall forces blank, then monitor
// RULE22: Negative drain turns on; first quadrant off
// RULE23: Temperature output high during overtemp
// RULE24: Latch reset counts continuous gate low
// RULE25: Comparators synchronised and filtered
module fault_protect
  import fault_prot_pkg::*;
#(
  parameter int SC_RESET_CYCLES = SC_RESET_DEFAULT
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Gate command from controller
  input wire logic gate_cmd,
  // Analog comparator inputs
  input wire logic oc_cmp,
  input wire logic sc_cmp,
  input wire logic fet_ot_cmp,
  input wire logic drv_ot_cmp,
  input wire logic uvlo_cmp,
  input wire logic slew_set_open,
  input wire logic drain_negative,
  input wire logic first_quadrant,
  input wire logic series_fet_on,
  // Overcurrent pin readback for strap
  input wire logic overcurrent_flag_in,
  // Power switch drive
  output logic fet_on,
  output logic slow_turnoff,
  output logic aux_rail_en,
  output logic neg_rail_en,
  output logic temp_pwm_force,
  // Fault pins
  output logic fault_n,
  output logic overcurrent_flag_n,
  output logic overcurrent_flag_oe
);
  logic gate_s;
  logic oc_s;
  logic sc_s;
  logic fet_ot_s;
  logic drv_ot_s;
  logic uvlo_s;
  logic open_s;
  logic dneg_s;
  logic q1_s;
  logic sfet_s;
  logic strap_s1_r;
  logic strap_s2_r;
  logic gate_d_r;
  logic gate_fall;
  logic [CNT_W-1:0] oc_dly_r;
  logic oc_delayed;
  logic oc_flag_r;
  logic sc_latch_r;
  logic [CNT_W-1:0] low_cnt_r;
  logic [CNT_W-1:0] blank_r;
  idm_state_type idm_r;
  idm_state_type idm_nxt;
  logic uvlo_d_r;
  logic uvlo_ok_s;
  logic drv_d_r;
  logic rails_r;
  logic started_r;
  logic combined_r;
  logic strap_done_r;
  logic idm_mode;
  logic fault_any;

  // Comparator inputs are synchronised and filtered
  sync_filter u_gate (.clk(clk), .srst(srst), .din(gate_cmd), .dout(gate_s)); // RULE25
  sync_filter u_oc (.clk(clk), .srst(srst), .din(oc_cmp), .dout(oc_s)); // RULE25
  sync_filter u_sc (.clk(clk), .srst(srst), .din(sc_cmp), .dout(sc_s)); // RULE25
  sync_filter u_fot (.clk(clk), .srst(srst), .din(fet_ot_cmp), .dout(fet_ot_s)); // RULE25
  sync_filter u_dot (.clk(clk), .srst(srst), .din(drv_ot_cmp), .dout(drv_ot_s)); // RULE25
  // Supply-good sense resets to not-good, so no false release edge follows reset
  sync_filter u_uv (.clk(clk), .srst(srst), .din(!uvlo_cmp), .dout(uvlo_ok_s));
  assign uvlo_s = !uvlo_ok_s;
  sync_filter u_open (.clk(clk), .srst(srst), .din(slew_set_open), .dout(open_s));
  sync_filter u_dneg (.clk(clk), .srst(srst), .din(drain_negative), .dout(dneg_s));
  sync_filter u_q1 (.clk(clk), .srst(srst), .din(first_quadrant), .dout(q1_s));
  sync_filter u_sfet (.clk(clk), .srst(srst), .din(series_fet_on), .dout(sfet_s));

  // Strap pin synchroniser
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      strap_s1_r <= 1'b1;
      strap_s2_r <= 1'b1;
    end
    else
    begin
      strap_s1_r <= overcurrent_flag_in;
      strap_s2_r <= strap_s1_r;
    end
  end

  // Strap captured once, before the pin is first driven
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      combined_r <= 1'b0;
      strap_done_r <= 1'b0;
    end
    else if (!strap_done_r && sfet_s)
    begin
      combined_r <= ~strap_s2_r; // RULE19
      strap_done_r <= 1'b1;
    end
  end

  assign gate_fall = gate_d_r & ~gate_s;

  always_ff @(posedge clk)
  begin
    if (srst)
      gate_d_r <= 1'b0;
    else
      gate_d_r <= gate_s;
  end

  // Delay line on overcurrent detection
  always_ff @(posedge clk)
  begin
    if (srst || !oc_s)
      oc_dly_r <= CNT_ZERO;
    else if (oc_dly_r < DETECT_DELAY_C)
      oc_dly_r <= oc_dly_r + CNT_ONE; // RULE3
  end

  assign oc_delayed = oc_s && (oc_dly_r >= DETECT_DELAY_C);

  // Cycle-by-cycle overcurrent flag
  always_ff @(posedge clk)
  begin
    if (srst)
      oc_flag_r <= 1'b0;
    else if (oc_delayed && !sc_latch_r && !sc_s)
      oc_flag_r <= 1'b1; // RULE1 RULE3
    else if (!gate_s)
      oc_flag_r <= 1'b0; // RULE2
  end

  // Short-circuit latch and its low-time reset
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sc_latch_r <= 1'b0;
      low_cnt_r <= CNT_ZERO;
    end
    else
    begin
      if (gate_s)
        low_cnt_r <= CNT_ZERO; // RULE24
      else if (low_cnt_r < CNT_W'(SC_RESET_CYCLES))
        low_cnt_r <= low_cnt_r + CNT_ONE;
      if (sc_s && !oc_flag_r && !oc_delayed)
        sc_latch_r <= 1'b1; // RULE4
      else if (low_cnt_r >= CNT_W'(SC_RESET_CYCLES))
        sc_latch_r <= 1'b0; // RULE6
    end
  end

  // Slowed turn-off while the short-circuit latch holds
  always_ff @(posedge clk)
  begin
    if (srst)
      slow_turnoff <= 1'b0;
    else
      slow_turnoff <= sc_latch_r; // RULE5
  end

  assign idm_mode = fet_ot_s && !drv_ot_s; // RULE9 RULE12 RULE14

  // Diode emulation state machine
  always_comb
  begin
    idm_nxt = idm_r;
    case (idm_r)
      IDM_BLANK:
        if (blank_r >= BLANK_C)
          idm_nxt = IDM_MONITOR; // RULE21
      IDM_MONITOR:
        if (dneg_s)
          idm_nxt = IDM_ON; // RULE22
      IDM_ON:
        if (q1_s)
          idm_nxt = IDM_MONITOR; // RULE10 RULE22
      default:
        idm_nxt = IDM_MONITOR;
    endcase
    if (gate_fall)
      idm_nxt = IDM_BLANK; // RULE21
    if (!idm_mode)
      idm_nxt = IDM_MONITOR;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      idm_r <= IDM_MONITOR;
    else
      idm_r <= idm_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (srst || idm_r != IDM_BLANK || gate_fall)
      blank_r <= CNT_ZERO;
    else if (blank_r < BLANK_C)
      blank_r <= blank_r + CNT_ONE;
  end

  // Rails follow lockout release and driver temperature
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      uvlo_d_r <= 1'b1;
      drv_d_r <= 1'b0;
      rails_r <= 1'b0;
    end
    else
    begin
      uvlo_d_r <= uvlo_s;
      drv_d_r <= drv_ot_s;
      if (drv_ot_s || uvlo_s)
        rails_r <= 1'b0; // RULE11 RULE16
      else if (uvlo_d_r && !uvlo_s)
        rails_r <= 1'b1; // RULE16
      else if (drv_d_r && !drv_ot_s)
        rails_r <= 1'b1; // RULE13 RULE14
    end
  end

  assign aux_rail_en = rails_r;
  assign neg_rail_en = rails_r;

  always_ff @(posedge clk)
  begin
    if (srst)
      started_r <= 1'b0;
    else if (sfet_s)
      started_r <= 1'b1; // RULE17
  end

  // Power switch drive, independent of fault pin use
  always_ff @(posedge clk)
  begin
    if (srst)
      fet_on <= 1'b0;
    else if (uvlo_s || drv_ot_s || !rails_r || sc_latch_r || (sc_s && !oc_flag_r))
      fet_on <= 1'b0; // RULE11 RULE15 RULE20
    else if (idm_mode)
      fet_on <= (idm_nxt == IDM_ON); // RULE10
    else if (oc_flag_r || oc_delayed)
      fet_on <= 1'b0; // RULE1
    else
      fet_on <= gate_s; // RULE2
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      temp_pwm_force <= 1'b0;
    else
      temp_pwm_force <= fet_ot_s || drv_ot_s; // RULE23
  end

  assign fault_any = !started_r || uvlo_s || fet_ot_s || drv_ot_s || open_s; // RULE13 RULE15 RULE18

  // Fault pin encoding
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fault_n <= 1'b0;
      overcurrent_flag_n <= 1'b1;
    end
    else
    begin
      fault_n <= !(fault_any || sc_latch_r || (combined_r && oc_flag_r)); // RULE8 RULE19
      overcurrent_flag_n <= !(sc_latch_r || oc_flag_r); // RULE7 RULE8
    end
  end

  // Push-pull drive once the strap is captured, unless strapped to ground
  assign overcurrent_flag_oe = strap_done_r && !combined_r; // RULE7 RULE19
endmodule // fault_protect

// >>> testbench/fault_protect_assertions.sv
// Checker on the protection block ports.
// Assumes a bind onto fault_protect.
`timescale 1ns/10ps
module fault_protect_assertions #(
  parameter int SC_RESET_CYCLES = 20
)
(
  // Clock, reset and inputs
  input wire logic clk,
  input wire logic srst,
  input wire logic gate_cmd,
  input wire logic fet_ot_cmp,
  input wire logic drv_ot_cmp,
  input wire logic uvlo_cmp,
  input wire logic slew_set_open,
  // Outputs
  input wire logic fet_on,
  input wire logic slow_turnoff,
  input wire logic aux_rail_en,
  input wire logic neg_rail_en,
  input wire logic temp_pwm_force,
  input wire logic fault_n,
  input wire logic overcurrent_flag_n,
  input wire logic overcurrent_flag_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence uv_low; uvlo_cmp [*8]; endsequence
  sequence drv_hot; drv_ot_cmp [*8]; endsequence
  sequence fet_hot; fet_ot_cmp [*8]; endsequence
  sequence pin_open; slew_set_open [*8]; endsequence
  sequence gate_low; !gate_cmd [*8]; endsequence
  sequence gate_high; gate_cmd [*8]; endsequence
  AST_UVLO: assert property (uv_low |=> !fet_on && !fault_n)
    else $error("switch on or fault high in lockout");
  AST_DRV_OT: assert property (drv_hot |=> !fet_on && !aux_rail_en && !neg_rail_en)
    else $error("driver overtemp left switch or rails on");
  AST_OT_FAULT: assert property (fet_hot |=> !fault_n && temp_pwm_force)
    else $error("overtemp not reported");
  AST_OPEN: assert property (pin_open |=> !fault_n)
    else $error("open slew pin not reported");
  AST_SLOW: assert property (slow_turnoff |-> !fet_on && !fault_n && !overcurrent_flag_n)
    else $error("short latch without off and code 00");
  AST_SC_HOLD: assert property (gate_high ##0 slow_turnoff |=> slow_turnoff)
    else $error("short latch released with gate high");
  AST_OC_CLR: assert property (gate_low ##0 overcurrent_flag_oe && !slow_turnoff
    |=> overcurrent_flag_n)
    else $error("overcurrent flag kept with gate low");
  AST_TEMP: assert property (temp_pwm_force |-> !fault_n)
    else $error("temperature force without fault");
endmodule // fault_protect_assertions

// >>> testbench/controller_model.sv
// Controller model: gate command source and overcurrent pin pull-up.
// Assumes the strap is set before reset release.
`timescale 1ns/10ps
module controller_model
(
  // Clock and control
  input wire logic clk,
  input wire logic run,
  input wire logic level,
  input wire logic strap_low,
  input wire logic [7:0] hi_len,
  input wire logic [7:0] lo_len,
  // Fault pin and gate
  input wire logic flag_n,
  input wire logic flag_oe,
  output logic gate_cmd,
  output logic flag_pin
);
  logic tog_r;
  logic [7:0] cnt_r;
  // Pulse train timing
  always_ff @(posedge clk)
  begin
    if (!run)
    begin
      cnt_r <= 8'h00;
      tog_r <= 1'b1;
    end
    else if (cnt_r == 8'h00)
    begin
      cnt_r <= tog_r ? hi_len : lo_len;
      tog_r <= !tog_r;
    end
    else
      cnt_r <= cnt_r - 8'h01;
  end
  // Held level gives the long low time for latch reset
  assign gate_cmd = run ? tog_r : level;
  // Pull-up unless strapped to ground
  assign flag_pin = flag_oe ? flag_n : !strap_low;
endmodule // controller_model

// >>> testbench/fault_protect_tb.sv
// Self-checking bench for the protection block.
// Assumes the package and design sources compile first.
`timescale 1ns/10ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module fault_protect_tb;
  logic clk = 1'b0, srst = 1'b1, chk = 1'b0, run = 1'b0, level = 1'b0, strap_low = 1'b0;
  logic oc_cmp = 1'b0, sc_cmp = 1'b0, fet_ot_cmp = 1'b0, drv_ot_cmp = 1'b0;
  logic uvlo_cmp = 1'b1, slew_set_open = 1'b0, drain_negative = 1'b0;
  logic first_quadrant = 1'b0, series_fet_on = 1'b0;
  logic [7:0] hi_len = 8'h08, lo_len = 8'h08;
  logic gate_cmd, flag_pin, fet_on, slow_turnoff, aux_rail_en, neg_rail_en, temp_pwm_force;
  logic fault_n, overcurrent_flag_n, overcurrent_flag_oe;
  logic [15:0] q[$];
  logic [15:0] e;
  int n_fail = 0, check_count = 0;
  integer seed = 32'hf60a;
  wire logic [7:0] outs = {fault_n, overcurrent_flag_n, overcurrent_flag_oe, fet_on,
    slow_turnoff, aux_rail_en, neg_rail_en, temp_pwm_force};
  always #25 clk = ~clk;
  controller_model controller_model_inst (.clk(clk), .run(run), .level(level),
    .strap_low(strap_low), .hi_len(hi_len), .lo_len(lo_len), .flag_n(overcurrent_flag_n),
    .flag_oe(overcurrent_flag_oe), .gate_cmd(gate_cmd), .flag_pin(flag_pin));
  fault_protect #(.SC_RESET_CYCLES(20)) fault_protect_inst (.clk(clk), .srst(srst),
    .gate_cmd(gate_cmd), .oc_cmp(oc_cmp), .sc_cmp(sc_cmp), .fet_ot_cmp(fet_ot_cmp),
    .drv_ot_cmp(drv_ot_cmp), .uvlo_cmp(uvlo_cmp), .slew_set_open(slew_set_open),
    .drain_negative(drain_negative), .first_quadrant(first_quadrant),
    .series_fet_on(series_fet_on), .overcurrent_flag_in(flag_pin), .fet_on(fet_on),
    .slow_turnoff(slow_turnoff), .aux_rail_en(aux_rail_en), .neg_rail_en(neg_rail_en),
    .temp_pwm_force(temp_pwm_force), .fault_n(fault_n),
    .overcurrent_flag_n(overcurrent_flag_n), .overcurrent_flag_oe(overcurrent_flag_oe));
  task w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task ex(input logic [7:0] m, input logic [7:0] v);
    q.push_back({m, v});
    chk <= 1'b1;
    @(posedge clk);
    chk <= 1'b0;
  endtask
  task finish_test;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(negedge clk)
    if (chk)
    begin
      e = q.pop_front();
      `CHK("outs", e[7:0], outs & e[15:8])
    end
  initial
  begin
    w(5);
    srst <= 1'b0;
    w(12);
    ex(8'hff, 8'h40);
    uvlo_cmp <= 1'b0;
    w(12);
    ex(8'hff, 8'h46);
    series_fet_on <= 1'b1;
    w(12);
    ex(8'hff, 8'he6);
    hi_len <= 8'(($random(seed) & 15) + 8);
    lo_len <= 8'(($random(seed) & 15) + 8);
    run <= 1'b1;
    w(80);
    run <= 1'b0;
    w(12);
    ex(8'hff, 8'he6);
    level <= 1'b1;
    w(12);
    ex(8'hff, 8'hf6);
    sc_cmp <= 1'b1;
    w(1);
    sc_cmp <= 1'b0;
    w(12);
    ex(8'hff, 8'hf6);
    oc_cmp <= 1'b1;
    w(12);
    ex(8'hff, 8'ha6);
    oc_cmp <= 1'b0;
    level <= 1'b0;
    w(12);
    ex(8'hff, 8'he6);
    level <= 1'b1;
    w(12);
    ex(8'hff, 8'hf6);
    sc_cmp <= 1'b1;
    oc_cmp <= 1'b1;
    w(12);
    ex(8'hff, 8'h2e);
    sc_cmp <= 1'b0;
    oc_cmp <= 1'b0;
    level <= 1'b0;
    w(10);
    ex(8'hff, 8'h2e);
    w(30);
    ex(8'hff, 8'he6);
    fet_ot_cmp <= 1'b1;
    w(12);
    ex(8'hff, 8'h67);
    drain_negative <= 1'b1;
    w(12);
    ex(8'hff, 8'h77);
    first_quadrant <= 1'b1;
    drain_negative <= 1'b0;
    w(12);
    ex(8'hff, 8'h67);
    first_quadrant <= 1'b0;
    drv_ot_cmp <= 1'b1;
    drain_negative <= 1'b1;
    w(12);
    ex(8'hff, 8'h61);
    drv_ot_cmp <= 1'b0;
    w(12);
    ex(8'hff, 8'h77);
    fet_ot_cmp <= 1'b0;
    drain_negative <= 1'b0;
    w(12);
    ex(8'hff, 8'he6);
    slew_set_open <= 1'b1;
    w(12);
    ex(8'hff, 8'h66);
    slew_set_open <= 1'b0;
    uvlo_cmp <= 1'b1;
    w(12);
    ex(8'hdf, 8'h40);
    srst <= 1'b1;
    strap_low <= 1'b1;
    w(8);
    srst <= 1'b0;
    uvlo_cmp <= 1'b0;
    w(12);
    level <= 1'b1;
    oc_cmp <= 1'b1;
    w(12);
    ex(8'hb0, 8'h00);
    finish_test;
  end
  initial
  begin
    w(2000);
    n_fail++;
    finish_test;
  end
endmodule // fault_protect_tb
bind fault_protect fault_protect_assertions #(.SC_RESET_CYCLES(SC_RESET_CYCLES))
  fault_protect_assertions_inst (.clk(clk), .srst(srst), .gate_cmd(gate_cmd),
  .fet_ot_cmp(fet_ot_cmp), .drv_ot_cmp(drv_ot_cmp), .uvlo_cmp(uvlo_cmp),
  .slew_set_open(slew_set_open), .fet_on(fet_on), .slow_turnoff(slow_turnoff),
  .aux_rail_en(aux_rail_en), .neg_rail_en(neg_rail_en), .temp_pwm_force(temp_pwm_force),
  .fault_n(fault_n), .overcurrent_flag_n(overcurrent_flag_n),
  .overcurrent_flag_oe(overcurrent_flag_oe));
